// ===== src/spi_flags_pkg.sv
package spi_flags_pkg;

  // ==========================================================================
  // Register map (byte addresses) and field positions.
  // ==========================================================================
  localparam logic [7:0]  RX_BUF_OFS     = 8'h00;
  localparam logic [7:0]  SHIFT_DATA_OFS = 8'h04;
  localparam logic [7:0]  IRQ_FLAG_OFS   = 8'h08;
  localparam logic [7:0]  IRQ_MASK_OFS   = 8'h0c;
  localparam logic [7:0]  RX_MIRROR_OFS  = 8'h10;

  localparam int          VACANT_BIT     = 31;
  localparam int          OVERRUN_BIT    = 30;
  localparam int          PENDING_BIT    = 29;
  localparam int          RX_IRQ_BIT     = 0;
  localparam int          OVR_IRQ_BIT    = 1;
  localparam int          WORD_BITS      = 16;
  localparam int          IRQ_BITS       = 2;

  localparam logic        VACANT_RESET   = 1'b1;
  localparam logic [1:0]  HTRANS_NONSEQ  = 2'b10;
  localparam logic [3:0]  LAST_BIT_COUNT = 4'hf;

  typedef logic [WORD_BITS-1:0] word_t;
  typedef logic [IRQ_BITS-1:0]  irq_t;

endpackage

// ===== src/shift_link_if.sv
interface shift_link_if;
  import spi_flags_pkg::*;

  word_t tx_word;
  logic  tx_taken;
  logic  rx_done;
  word_t rx_word;

  modport core
  (
    output tx_word,
    input  tx_taken,
    input  rx_done,
    input  rx_word
  );

  modport shifter
  (
    input  tx_word,
    output tx_taken,
    output rx_done,
    output rx_word
  );
endinterface

// ===== src/spi_word_shifter.sv
module spi_word_shifter
  import spi_flags_pkg::*;
(
  input  wire logic   hclk,
  input  wire logic   hresetn,
  input  wire logic   sclk_in,
  input  wire logic   cs_n_in,
  input  wire logic   mosi_in,
  output logic        miso_out,
  output logic        miso_oe_n,
  shift_link_if.shifter link
);

  // ==========================================================================
  // Pin synchronisers.
  // ==========================================================================
  logic [2:0] sclk_sync_reg;
  logic [1:0] cs_sync_reg;
  logic [1:0] mosi_sync_reg;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      sclk_sync_reg <= 3'h0;
      cs_sync_reg   <= 2'h3;
      mosi_sync_reg <= 2'h0;
    end
    else
    begin
      sclk_sync_reg <= {sclk_sync_reg[1:0], sclk_in};
      cs_sync_reg   <= {cs_sync_reg[0], cs_n_in};
      mosi_sync_reg <= {mosi_sync_reg[0], mosi_in};
    end
  end

  // ==========================================================================
  // Mode 0 slave shifter: sample on rising edges, drive on falling edges.
  // ==========================================================================
  logic  sclk_rise;
  logic  sclk_fall;
  logic  selected;
  logic  cs_prev_reg;
  logic  cs_prev_next;
  logic  active_reg;
  logic  active_next;
  logic  [3:0] count_reg;
  logic  [3:0] count_next;
  word_t tx_sh_reg;
  word_t tx_sh_next;
  word_t rx_sh_reg;
  word_t rx_sh_next;
  word_t rx_word_reg;
  word_t rx_word_next;
  logic  done_reg;
  logic  done_next;
  logic  taken_reg;
  logic  taken_next;
  logic  miso_reg;
  logic  miso_next;
  logic  oe_n_reg;
  logic  oe_n_next;

  assign sclk_rise = sclk_sync_reg[1] & ~sclk_sync_reg[2];
  assign sclk_fall = ~sclk_sync_reg[1] & sclk_sync_reg[2];
  assign selected  = ~cs_sync_reg[1];

  always_comb
  begin
    cs_prev_next = cs_sync_reg[1];
    active_next  = active_reg;
    count_next   = count_reg;
    tx_sh_next   = tx_sh_reg;
    rx_sh_next   = rx_sh_reg;
    rx_word_next = rx_word_reg;
    done_next    = 1'b0;
    taken_next   = 1'b0;
    miso_next    = miso_reg;
    oe_n_next    = ~selected;
    if (selected && cs_prev_reg)
    begin
      // Frame start moves the pending word into the shifter.
      active_next = 1'b1;
      count_next  = 4'h0;
      tx_sh_next  = link.tx_word;
      miso_next   = link.tx_word[WORD_BITS-1];
      taken_next  = 1'b1;
    end
    else if (!selected)
    begin
      active_next = 1'b0;
    end
    else if (active_reg && sclk_rise)
    begin
      // MSB enters first, so a finished word is already right-justified.
      rx_sh_next = {rx_sh_reg[WORD_BITS-2:0], mosi_sync_reg[1]};
      count_next = count_reg + 4'h1;
      if (count_reg == LAST_BIT_COUNT)
      begin
        // Extra clocks after the sixteenth bit must not start a second word
        // until select is released and asserted again.
        rx_word_next = {rx_sh_reg[WORD_BITS-2:0], mosi_sync_reg[1]};
        done_next    = 1'b1;
        active_next  = 1'b0;
      end
    end
    else if (active_reg && sclk_fall)
    begin
      tx_sh_next = {tx_sh_reg[WORD_BITS-2:0], 1'b0};
      miso_next  = tx_sh_reg[WORD_BITS-2];
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      cs_prev_reg <= 1'b1;
      active_reg  <= 1'b0;
      count_reg   <= 4'h0;
      tx_sh_reg   <= '0;
      rx_sh_reg   <= '0;
      rx_word_reg <= '0;
      done_reg    <= 1'b0;
      taken_reg   <= 1'b0;
      miso_reg    <= 1'b0;
      oe_n_reg    <= 1'b1;
    end
    else
    begin
      cs_prev_reg <= cs_prev_next;
      active_reg  <= active_next;
      count_reg   <= count_next;
      tx_sh_reg   <= tx_sh_next;
      rx_sh_reg   <= rx_sh_next;
      rx_word_reg <= rx_word_next;
      done_reg    <= done_next;
      taken_reg   <= taken_next;
      miso_reg    <= miso_next;
      oe_n_reg    <= oe_n_next;
    end
  end

  assign link.rx_done  = done_reg;
  assign link.rx_word  = rx_word_reg;
  assign link.tx_taken = taken_reg;
  assign miso_out      = miso_reg;
  assign miso_oe_n     = oe_n_reg;

endmodule

// ===== src/spi_buffer_status_flags.sv
// Implementation choices: the AHB-Lite interface to the registers and the placing of the registers.
module spi_buffer_status_flags
  import spi_flags_pkg::*;
(
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic        sclk_in,
  input  wire logic        cs_n_in,
  input  wire logic        mosi_in,
  output logic             miso_out,
  output logic             miso_oe_n,
  output logic             irq
);
  import spi_flags_pkg::*;

  shift_link_if link ();

  spi_word_shifter u_shifter
  (
    .hclk      (hclk),
    .hresetn   (hresetn),
    .sclk_in   (sclk_in),
    .cs_n_in   (cs_n_in),
    .mosi_in   (mosi_in),
    .miso_out  (miso_out),
    .miso_oe_n (miso_oe_n),
    .link      (link.shifter)
  );

  // ==========================================================================
  // Bus decode.
  // ==========================================================================
  function automatic logic hit(input logic [31:0] addr, input logic [7:0] ofs);
    hit = (addr[7:0] == ofs) && (addr[31:8] == 24'h0);
  endfunction

  logic addr_phase;
  logic rd_take;
  logic wr_take;

  assign addr_phase = hsel && (htrans == HTRANS_NONSEQ) && hready;
  assign rd_take    = addr_phase && !hwrite;
  assign wr_take    = addr_phase && hwrite;

  // ==========================================================================
  // State and next values.
  // ==========================================================================
  logic        vacant_reg;
  logic        vacant_next;
  logic        overrun_reg;
  logic        overrun_next;
  logic        pending_reg;
  logic        pending_next;
  word_t       rx_data_reg;
  word_t       rx_data_next;
  word_t       tx_data_reg;
  word_t       tx_data_next;
  irq_t        flags_reg;
  irq_t        flags_next;
  irq_t        mask_reg;
  irq_t        mask_next;
  logic        wr_pend_reg;
  logic        wr_pend_next;
  logic [31:0] wr_addr_reg;
  logic [31:0] wr_addr_next;
  logic [31:0] rdata_reg;
  logic [31:0] rdata_next;
  logic        irq_reg;
  logic        irq_next;
  logic        buf_read;
  logic        wr_shift;
  logic        wr_flags;
  logic        wr_mask;
  logic [31:0] status_word;

  assign buf_read    = rd_take && hit(haddr, RX_BUF_OFS);
  assign wr_shift    = wr_pend_reg && hit(wr_addr_reg, SHIFT_DATA_OFS);
  assign wr_flags    = wr_pend_reg && hit(wr_addr_reg, IRQ_FLAG_OFS);
  assign wr_mask     = wr_pend_reg && hit(wr_addr_reg, IRQ_MASK_OFS);
  assign status_word = {vacant_reg, overrun_reg, pending_reg, 13'h0, rx_data_reg};

  assign link.tx_word = tx_data_reg;

  always_comb
  begin
    vacant_next  = vacant_reg;
    overrun_next = overrun_reg;
    pending_next = pending_reg;
    rx_data_next = rx_data_reg;
    tx_data_next = tx_data_reg;
    flags_next   = flags_reg;
    mask_next    = mask_reg;
    wr_pend_next = wr_take;
    wr_addr_next = wr_take ? haddr : wr_addr_reg;
    rdata_next   = 32'h0;

    // Read side effects happen when the address phase is taken, so the
    // returned word shows the flags as they were before the read.
    if (rd_take)
    begin
      if (hit(haddr, RX_BUF_OFS))
      begin
        rdata_next = status_word;
      end
      else if (hit(haddr, SHIFT_DATA_OFS))
      begin
        rdata_next = {16'h0, tx_data_reg};
      end
      else if (hit(haddr, IRQ_FLAG_OFS))
      begin
        rdata_next = {30'h0, flags_reg};
      end
      else if (hit(haddr, IRQ_MASK_OFS))
      begin
        rdata_next = {30'h0, mask_reg};
      end
      else if (hit(haddr, RX_MIRROR_OFS))
      begin
        rdata_next = {16'h0, rx_data_reg};
      end
    end
    if (buf_read)
    begin
      vacant_next              = 1'b1;
      overrun_next             = 1'b0;
      flags_next[RX_IRQ_BIT]  = 1'b0;
      flags_next[OVR_IRQ_BIT] = 1'b0;
    end

    // Only the shift-data and interrupt registers take writes; of the status
    // flags in the buffer word only pending changes, set by a shift-data write.
    if (wr_shift)
    begin
      tx_data_next = hwdata[WORD_BITS-1:0];
    end
    if (wr_mask)
    begin
      mask_next = hwdata[IRQ_BITS-1:0];
    end
    if (wr_flags)
    begin
      flags_next = flags_next & ~hwdata[IRQ_BITS-1:0];
    end

    // Hardware events follow reads and clears so those lose; a shift-data write still beats tx_taken.
    if (link.tx_taken)
    begin
      pending_next = 1'b0;
    end
    if (wr_shift)
    begin
      pending_next = 1'b1;
    end
    if (link.rx_done)
    begin
      rx_data_next            = link.rx_word;
      vacant_next             = 1'b0;
      flags_next[RX_IRQ_BIT] = 1'b1;
      if (!vacant_reg)
      begin
        overrun_next             = 1'b1;
        flags_next[OVR_IRQ_BIT] = 1'b1;
      end
    end

    irq_next = |(flags_next & mask_next);
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      vacant_reg  <= VACANT_RESET;
      overrun_reg <= 1'b0;
      pending_reg <= 1'b0;
      rx_data_reg <= '0;
      tx_data_reg <= '0;
      flags_reg   <= '0;
      mask_reg    <= '0;
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= 32'h0;
      rdata_reg   <= 32'h0;
      irq_reg     <= 1'b0;
      hreadyout   <= 1'b0;
    end
    else
    begin
      vacant_reg  <= vacant_next;
      overrun_reg <= overrun_next;
      pending_reg <= pending_next;
      rx_data_reg <= rx_data_next;
      tx_data_reg <= tx_data_next;
      flags_reg   <= flags_next;
      mask_reg    <= mask_next;
      wr_pend_reg <= wr_pend_next;
      wr_addr_reg <= wr_addr_next;
      rdata_reg   <= rdata_next;
      irq_reg     <= irq_next;
      hreadyout   <= 1'b1;
    end
  end

  // ==========================================================================
  // Outputs. The slave never inserts wait states and always answers OKAY.
  // ==========================================================================
  assign hrdata = rdata_reg;
  assign irq    = irq_reg;
  assign hresp  = 1'b0;

endmodule

// ===== tb/spi_master_model.sv
module spi_master_model
  import spi_flags_pkg::*;
(
  output logic      sclk,
  output logic      cs_n,
  output logic      mosi,
  input  wire logic miso
);
  timeunit 1ns;
  timeprecision 1ns;

  // ==========================================================================
  // Mode 0 master, clock idle low between frames.
  // ==========================================================================
  initial
  begin
    sclk = 1'b0;
    cs_n = 1'b1;
    mosi = 1'b0;
  end

  // Sampling late in the high phase gives the slave's synchronised output time.
  task automatic xfer(input word_t tx_d, output word_t got);
    // Start off the system clock edge so no link pin changes as it is sampled.
    #2 cs_n = 1'b0;
    #80;
    for (int i = WORD_BITS - 1; i >= 0; i--)
    begin
      mosi = tx_d[i];
      #40 sclk = 1'b1;
      #35 got[i] = miso;
      #5 sclk = 1'b0;
    end
    #40 cs_n = 1'b1;
    mosi = ~mosi;
  endtask
endmodule

// ===== tb/spi_buffer_status_flags_chk.sv
module spi_buffer_status_flags_chk
  import spi_flags_pkg::*;
(
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic        hready,
  input wire logic [31:0] hrdata,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic        cs_n_in,
  input wire logic        miso_oe_n
);
  timeunit 1ns;
  timeprecision 1ns;

  // ==========================================================================
  // Helpers.
  // ==========================================================================
  logic       take;
  logic [3:0] quiet_reg;

  assign take = hsel && htrans == HTRANS_NONSEQ && hready;

  // Idle-select count, so a late copy from a frame is never taken for a fault.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      quiet_reg <= 4'h0;
    else if (!cs_n_in)
      quiet_reg <= 4'h0;
    else if (quiet_reg != 4'hf)
      quiet_reg <= quiet_reg + 4'h1;
  end

  // ==========================================================================
  // Properties.
  // ==========================================================================
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  sequence s_rd_buf;
    take && !hwrite && haddr == {24'h0, RX_BUF_OFS};
  endsequence
  sequence s_rd_quiet;
    s_rd_buf ##0 quiet_reg > 4'h7;
  endsequence
  sequence s_wr_shift;
    take && hwrite && haddr == {24'h0, SHIFT_DATA_OFS};
  endsequence

  chk_read_sets_vacant: assert property (s_rd_buf ##[1:4] s_rd_quiet |=> hrdata[VACANT_BIT])
    else $error("vacant flag not set after a buffer read");
  chk_read_clears_ovr: assert property (s_rd_buf ##[1:4] s_rd_quiet |=> !hrdata[OVERRUN_BIT])
    else $error("overrun flag survived a buffer read");
  chk_write_sets_pending: assert property (s_wr_shift ##[2:5] s_rd_quiet |=> hrdata[PENDING_BIT])
    else $error("pending flag not set by shift data write");
  chk_mirror_no_status: assert property (take && !hwrite && haddr == {24'h0, RX_MIRROR_OFS}
    |=> hrdata[31:16] == 16'h0)
    else $error("mirror shows upper bits");
  chk_idle_rdata_zero: assert property (!(take && !hwrite) |=> hrdata == 32'h0)
    else $error("read data not zero outside a read");
  chk_resp_okay: assert property (take |=> hresp == 1'b0 && hreadyout)
    else $error("response not okay");
  chk_ready_after_reset: assert property ($past(hresetn) |-> hreadyout)
    else $error("ready low after reset");
  chk_miso_released: assert property (quiet_reg > 4'h5 |-> miso_oe_n)
    else $error("serial output driven while deselected");
endmodule

bind spi_buffer_status_flags spi_buffer_status_flags_chk i_chk (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
  .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
  .hresp(hresp), .cs_n_in(cs_n_in), .miso_oe_n(miso_oe_n));

// ===== tb/testbench.sv
module testbench import spi_flags_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;

  // ==========================================================================
  // Signals and design.
  // ==========================================================================
  logic        hclk = 1'b0;
  logic        hresetn, hsel, hwrite, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata, e;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic        sclk, cs_n, mosi, miso_out, miso_oe_n, irq, miso_line;
  logic        rd_dph = 1'b0;
  logic [15:0] seed = 16'h0042;
  word_t       txw, rxw;
  logic [31:0] q[$];
  int          n_mismatch = 0;
  int          n_compared = 0;

  always #5 hclk = ~hclk;
  assign miso_line = miso_oe_n ? ~miso_out : miso_out;

  spi_buffer_status_flags i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .sclk_in(sclk), .cs_n_in(cs_n), .mosi_in(mosi),
    .miso_out(miso_out), .miso_oe_n(miso_oe_n), .irq(irq));
  spi_master_model i_spi (.sclk(sclk), .cs_n(cs_n), .mosi(mosi), .miso(miso_line));

  // ==========================================================================
  // Tasks.
  // ==========================================================================
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  task automatic check(input string n, input logic [31:0] s, input logic [31:0] x);
    n_compared++;
    if (s !== x)
    begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", n, x, s);
    end
  endtask

  task automatic tally_and_finish();
    if (n_mismatch == 0 && n_compared > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= HTRANS_NONSEQ;
    hwrite <= w;
    haddr <= {24'h0, a};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] x);
    q.push_back(x);
    bus(1'b0, a, 32'h0);
  endtask

  task automatic frame();
    word_t got;
    seed = lfsr(seed);
    rxw = seed;
    i_spi.xfer(rxw, got);
    repeat (10) @(posedge hclk);
    check("miso word", {16'h0, got}, {16'h0, txw});
  endtask

  // Read data stands in the cycle after the address phase is taken.
  always @(posedge hclk)
  begin
    if (rd_dph && hreadyout === 1'b1)
    begin
      e = q.pop_front();
      check("hrdata", hrdata, e);
    end
    rd_dph = hsel && htrans == HTRANS_NONSEQ && hreadyout && !hwrite;
  end

  initial
  begin
    #300000;
    n_mismatch++;
    tally_and_finish();
  end

  // ==========================================================================
  // Main sequence.
  // ==========================================================================
  initial
  begin
    hresetn = 1'b0;
    hsel = 1'b0;
    htrans = 2'b00;
    hwrite = 1'b0;
    haddr = 32'h0;
    hwdata = 32'h0;
    hsize = 3'b010;
    txw = 16'h0;
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (2) @(posedge hclk);
    rd(RX_BUF_OFS, 32'h80000000);
    rd(IRQ_MASK_OFS, 32'h0);
    bus(1'b1, RX_BUF_OFS, 32'h0);
    seed = lfsr(seed);
    txw = seed;
    bus(1'b1, SHIFT_DATA_OFS, {16'h0, txw});
    rd(SHIFT_DATA_OFS, {16'h0, txw});
    rd(RX_BUF_OFS, 32'ha0000000);
    bus(1'b1, IRQ_MASK_OFS, 32'h3);
    frame();
    check("irq", {31'h0, irq}, 32'h1);
    rd(RX_MIRROR_OFS, {16'h0, rxw});
    rd(IRQ_FLAG_OFS, 32'h1);
    rd(RX_BUF_OFS, {16'h0, rxw});
    rd(IRQ_FLAG_OFS, 32'h0);
    check("irq", {31'h0, irq}, 32'h0);
    frame();
    frame();
    rd(IRQ_FLAG_OFS, 32'h3);
    rd(RX_BUF_OFS, {16'h4000, rxw});
    rd(RX_BUF_OFS, {16'h8000, rxw});
    bus(1'b1, IRQ_MASK_OFS, 32'h0);
    frame();
    check("irq", {31'h0, irq}, 32'h0);
    rd(IRQ_FLAG_OFS, 32'h1);
    bus(1'b1, IRQ_FLAG_OFS, 32'h1);
    rd(IRQ_FLAG_OFS, 32'h0);
    rd(8'h40, 32'h0);
    bus(1'b1, 8'h40, 32'hffffffff);
    rd(8'h40, 32'h0);
    repeat (3) @(posedge hclk);
    check("queue", 32'(q.size()), 32'h0);
    tally_and_finish();
  end
endmodule
